// ### rtl/pmst_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pmst_regs
  import pmst_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic               cmd_valid_i,
  input  wire logic [7:0]         cmd_code_i,
  input  wire logic               input_undervolt_fault_i,
  input  wire logic               input_undervolt_warning_i,
  input  wire logic               input_overvolt_warning_i,
  input  wire logic               input_overvolt_fault_i,
  input  wire logic               ext_overtemp_warning_i,
  input  wire logic               ext_overtemp_fault_i,
  input  wire logic               die_overtemp_warning_i,
  input  wire logic               die_overtemp_fault_i,
  input  wire logic               bus_timeout_format_fault_i,
  input  wire logic               packet_check_fault_i,
  input  wire logic               bad_command_fault_i,
  input  wire logic               telem_update_i,
  input  wire logic [TELEM_W-1:0] input_voltage_value_i,
  input  wire logic [TELEM_W-1:0] output_voltage_value_i,
  input  wire logic [EXP_W-1:0]   output_voltage_exp_i,
  input  wire logic [TELEM_W-1:0] output_current_value_i,
  input  wire logic [TELEM_W-1:0] external_temp_value_i,
  input  wire logic [TELEM_W-1:0] die_temp_value_i,
  output logic                    rsp_valid_o,
  output logic      [TELEM_W-1:0] rsp_data_o,
  output logic      [1:0]         rsp_bytes_o,
  output logic                    rsp_unsupported_o,
  output logic                    alert_o,
  output logic      [TELEM_W-1:0] status_summary_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // command decoding, shared by the answer path and the fault path

  function automatic pmst_kind_t cmd_kind(input logic [7:0] code);
    unique case (code)
      CMD_CLEAR_FAULTS:  cmd_kind = KIND_CLEAR;
      CMD_OUTPUT_VOLTAGE_VALUE_MODE:     cmd_kind = KIND_MODE;
      CMD_STAT_INPUT,
      CMD_STAT_EXT_TEMP,
      CMD_STAT_COMM,
      CMD_STAT_VENDOR:   cmd_kind = KIND_STATUS;
      CMD_INPUT_VOLTAGE_READING,
      CMD_OUTPUT_VOLTAGE_READING,
      CMD_OUTPUT_CURRENT_READING,
      CMD_READ_EXT_TEMP,
      CMD_READ_DIE_TEMP: cmd_kind = KIND_TELEM;
      default:           cmd_kind = KIND_BAD;
    endcase
  endfunction

  function automatic logic [1:0] grp_of(input logic [7:0] code);
    unique case (code)
      CMD_STAT_EXT_TEMP: grp_of = 2'(GRP_EXT);
      CMD_STAT_COMM:     grp_of = 2'(GRP_COMM);
      CMD_STAT_VENDOR:   grp_of = 2'(GRP_DIE);
      default:           grp_of = 2'(GRP_IN);
    endcase
  endfunction

  function automatic logic [2:0] chan_of(input logic [7:0] code);
    unique case (code)
      CMD_OUTPUT_VOLTAGE_READING:     chan_of = 3'(CH_OUTPUT_VOLTAGE_VALUE);
      CMD_OUTPUT_CURRENT_READING:     chan_of = 3'(CH_OUTPUT_CURRENT_VALUE);
      CMD_READ_EXT_TEMP: chan_of = 3'(CH_EXT);
      CMD_READ_DIE_TEMP: chan_of = 3'(CH_DIE);
      default:           chan_of = 3'(CH_VIN);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state and sub-blocks

  pmst_top_state_t s;
  pmst_top_state_t next_s;

  logic [NUM_GRP-1:0][STAT_W-1:0]  grp_evt;
  logic [NUM_GRP-1:0][STAT_W-1:0]  grp_latched;
  logic [NUM_CH-1:0][TELEM_W-1:0]  telem_vals;
  logic [NUM_CH-1:0][TELEM_W-1:0]  telem_snap;
  pmst_kind_t                      kind;

  pmst_stat_if #(.W(STAT_W)) grp_if [NUM_GRP] ();

  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++)
    begin : gen_grp
      assign grp_if[g].evt   = grp_evt[g];
      assign grp_if[g].clr   = s.clear;
      assign grp_latched[g]  = grp_if[g].latched;
      pmst_sticky #(
        .W    (STAT_W),
        .MASK (GRP_MASK[g])
      ) u_sticky (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .stat       (grp_if[g])
      );
    end
  endgenerate

  pmst_telem #(
    .W (TELEM_W),
    .N (NUM_CH)
  ) u_telem (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .update_i   (telem_update_i),
    .values_i   (telem_vals),
    .snap_o     (telem_snap)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // fault sources onto their status bit positions

  always_comb
  begin
    grp_evt = '0;
    grp_evt[GRP_IN][IN_UV_FAULT_BIT]  = input_undervolt_fault_i;
    grp_evt[GRP_IN][IN_UV_WARN_BIT]   = input_undervolt_warning_i;
    grp_evt[GRP_IN][IN_OV_WARN_BIT]   = input_overvolt_warning_i;
    grp_evt[GRP_IN][IN_OV_FAULT_BIT]  = input_overvolt_fault_i;
    grp_evt[GRP_EXT][TEMP_WARN_BIT]   = ext_overtemp_warning_i;
    grp_evt[GRP_EXT][TEMP_FAULT_BIT]  = ext_overtemp_fault_i;
    grp_evt[GRP_COMM][COMM_BUS_BIT]   = bus_timeout_format_fault_i;
    grp_evt[GRP_COMM][COMM_PEC_BIT]   = packet_check_fault_i;
    grp_evt[GRP_COMM][COMM_CMD_BIT]   = bad_command_fault_i | s.cmd_fault;
    grp_evt[GRP_DIE][TEMP_WARN_BIT]   = die_overtemp_warning_i;
    grp_evt[GRP_DIE][TEMP_FAULT_BIT]  = die_overtemp_fault_i;
  end

  always_comb
  begin
    telem_vals          = '0;
    telem_vals[CH_VIN]  = input_voltage_value_i;
    telem_vals[CH_OUTPUT_VOLTAGE_VALUE] = output_voltage_value_i;
    telem_vals[CH_OUTPUT_CURRENT_VALUE] = output_current_value_i;
    telem_vals[CH_EXT]  = external_temp_value_i;
    telem_vals[CH_DIE]  = die_temp_value_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command sequencer: take in idle, answer one cycle later

  assign kind = cmd_kind(s.code);

  always_comb
  begin
    next_s                 = s;
    next_s.rsp_valid       = 1'b0;
    next_s.rsp_unsupported = 1'b0;
    next_s.clear           = 1'b0;
    next_s.cmd_fault       = 1'b0;
    unique case (s.fsm)
      ST_IDLE:
      begin
        // a request during the answer cycle is dropped; the transport serialises
        if (cmd_valid_i)
        begin
          next_s.code = cmd_code_i;
          next_s.fsm  = ST_ANSWER;
        end
      end
      ST_ANSWER:
      begin
        next_s.fsm       = ST_IDLE;
        next_s.rsp_valid = 1'b1;
        next_s.rsp_data  = WORD_RESET;
        next_s.rsp_bytes = BYTES_NONE;
        unique case (kind)
          KIND_STATUS:
          begin
            next_s.rsp_data  = {BYTE_PAD, grp_latched[grp_of(s.code)]};
            next_s.rsp_bytes = BYTES_ONE;
          end
          KIND_TELEM:
          begin
            // output voltage carries mantissa only; exponent via mode byte
            next_s.rsp_data  = telem_snap[chan_of(s.code)];
            next_s.rsp_bytes = BYTES_TWO;
          end
          KIND_MODE:
          begin
            next_s.rsp_data  = {BYTE_PAD, OUTPUT_VOLTAGE_VALUE_MODE_LINEAR, output_voltage_exp_i};
            next_s.rsp_bytes = BYTES_ONE;
          end
          KIND_CLEAR:
          begin
            next_s.clear = 1'b1;
          end
          KIND_BAD:
          begin
            next_s.rsp_unsupported = 1'b1;
            next_s.cmd_fault       = 1'b1;
          end
        endcase
      end
    endcase

    // alert follows latched bits, so it drops one edge after the clear lands
    next_s.alert   = |grp_latched;
    next_s.summary = '0;
    next_s.summary[SUM_INPUT_BIT]  = |grp_latched[GRP_IN];
    next_s.summary[SUM_VENDOR_BIT] = |grp_latched[GRP_DIE];
    next_s.summary[SUM_TEMP_BIT]   = |grp_latched[GRP_EXT];
    next_s.summary[SUM_COMM_BIT]   = |grp_latched[GRP_COMM];
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops

  assign rsp_valid_o       = s.rsp_valid;
  assign rsp_data_o        = s.rsp_data;
  assign rsp_bytes_o       = s.rsp_bytes;
  assign rsp_unsupported_o = s.rsp_unsupported;
  assign alert_o           = s.alert;
  assign status_summary_o  = s.summary;
endmodule
`default_nettype wire

// ### rtl/pmst_pkg.sv
// Behaviour
// - input status bit 4 latches on input under-voltage fault.
// - input status bit 5 latches on input under-voltage warning.
// - input status bit 6 latches on input over-voltage warning.
// - input status bit 7 latches on input over-voltage fault.
// - external temperature status bit 6 latches on over-temperature warning.
// - external temperature status bit 7 latches on over-temperature fault.
// - communication status bit 1 latches on bus timeout or malformed transaction.
// - communication status bit 5 latches on packet error check mismatch.
// - communication status bit 7 latches on invalid or unsupported command code.
// - vendor status bit 6 latches on die over-temperature warning.
// - vendor status bit 7 latches on die over-temperature fault.
// - input voltage reading returns a 16-bit linear-format word.
// - output voltage reading returns a 16-bit mantissa without exponent.
// - output current reading returns a 16-bit linear-format word.
// - first temperature command returns external temperature, 16-bit linear format.
// - second temperature command returns die temperature, 16-bit linear format.
// - mode byte holds exponent in bits 4:0, bits 7:5 read 000.
// - clear-faults empties latched bits, drops alert; present faults set again.
// - summary bit 13 set whenever any input warning or fault bit is set.
package pmst_pkg;
  localparam int STAT_W  = 8;
  localparam int TELEM_W = 16;
  localparam int EXP_W   = 5;
  localparam int NUM_GRP = 4;
  localparam int NUM_CH  = 5;

  localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_VALUE_MODE     = 8'h20;
  localparam logic [7:0] CMD_STAT_INPUT    = 8'h7C;
  localparam logic [7:0] CMD_STAT_EXT_TEMP = 8'h7D;
  localparam logic [7:0] CMD_STAT_COMM     = 8'h7E;
  localparam logic [7:0] CMD_STAT_VENDOR   = 8'h80;
  localparam logic [7:0] CMD_INPUT_VOLTAGE_READING      = 8'h88;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READING     = 8'h8B;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_READING     = 8'h8C;
  localparam logic [7:0] CMD_READ_EXT_TEMP = 8'h8D;
  localparam logic [7:0] CMD_READ_DIE_TEMP = 8'h8E;

  localparam int IN_UV_FAULT_BIT = 4;
  localparam int IN_UV_WARN_BIT  = 5;
  localparam int IN_OV_WARN_BIT  = 6;
  localparam int IN_OV_FAULT_BIT = 7;
  localparam int TEMP_WARN_BIT   = 6;
  localparam int TEMP_FAULT_BIT  = 7;
  localparam int COMM_BUS_BIT    = 1;
  localparam int COMM_PEC_BIT    = 5;
  localparam int COMM_CMD_BIT    = 7;

  localparam int SUM_COMM_BIT  = 1;
  localparam int SUM_TEMP_BIT  = 2;
  localparam int SUM_VENDOR_BIT = 12;
  localparam int SUM_INPUT_BIT = 13;

  localparam int GRP_IN   = 0;
  localparam int GRP_EXT  = 1;
  localparam int GRP_COMM = 2;
  localparam int GRP_DIE  = 3;
  localparam logic [NUM_GRP-1:0][STAT_W-1:0] GRP_MASK = {8'hC0, 8'hA2, 8'hC0, 8'hF0};

  localparam int CH_VIN  = 0;
  localparam int CH_OUTPUT_VOLTAGE_VALUE = 1;
  localparam int CH_OUTPUT_CURRENT_VALUE = 2;
  localparam int CH_EXT  = 3;
  localparam int CH_DIE  = 4;

  localparam logic [2:0]         OUTPUT_VOLTAGE_VALUE_MODE_LINEAR = 3'h0;
  localparam logic [7:0]         BYTE_PAD         = 8'h00;
  localparam logic [STAT_W-1:0]  STAT_RESET       = 8'h00;
  localparam logic [TELEM_W-1:0] WORD_RESET       = 16'h0000;
  localparam logic [1:0]         BYTES_NONE       = 2'h0;
  localparam logic [1:0]         BYTES_ONE        = 2'h1;
  localparam logic [1:0]         BYTES_TWO        = 2'h2;

  typedef enum logic [2:0] {KIND_BAD, KIND_CLEAR, KIND_MODE, KIND_STATUS, KIND_TELEM} pmst_kind_t;
  typedef enum logic [0:0] {ST_IDLE, ST_ANSWER} pmst_fsm_t;

  typedef struct packed {
    pmst_fsm_t          fsm;
    logic [7:0]         code;
    logic               rsp_valid;
    logic [TELEM_W-1:0] rsp_data;
    logic [1:0]         rsp_bytes;
    logic               rsp_unsupported;
    logic               clear;
    logic               cmd_fault;
    logic               alert;
    logic [TELEM_W-1:0] summary;
  } pmst_top_state_t;
endpackage

// ### rtl/pmst_stat_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pmst_stat_if #(parameter int W = 8);
  logic [W-1:0] evt;
  logic         clr;
  logic [W-1:0] latched;
  modport latch (input evt, input clr, output latched);
  modport owner (output evt, output clr, input latched);
endinterface
`default_nettype wire

// ### rtl/pmst_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module pmst_sticky
  import pmst_pkg::*;
#(
  parameter int              W    = STAT_W,
  parameter logic [W-1:0]    MASK = '1
)
(
  input  wire logic  core_clk_i,
  input  wire logic  rst_i,
  pmst_stat_if.latch stat
);
  typedef struct packed {
    logic [W-1:0] latched;
  } pmst_sticky_state_t;

  pmst_sticky_state_t s;
  pmst_sticky_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // set wins over clear: a fault still present re-latches in the clear cycle
  always_comb
  begin
    next_s = s;
    if (stat.clr)
    begin
      next_s.latched = stat.evt & MASK;
    end
    else
    begin
      next_s.latched = (s.latched | stat.evt) & MASK;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign stat.latched = s.latched;
endmodule
`default_nettype wire

// ### rtl/pmst_telem.sv
`timescale 1ns/1ps
`default_nettype none
module pmst_telem
  import pmst_pkg::*;
#(
  parameter int W = TELEM_W,
  parameter int N = NUM_CH
)
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                update_i,
  input  wire logic [N-1:0][W-1:0] values_i,
  output logic      [N-1:0][W-1:0] snap_o
);
  typedef struct packed {
    logic [N-1:0][W-1:0] snap;
  } pmst_telem_state_t;

  pmst_telem_state_t s;
  pmst_telem_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // all channels move together so one strobe gives a coherent set
  always_comb
  begin
    next_s = s;
    if (update_i)
    begin
      next_s.snap = values_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign snap_o = s.snap;
endmodule
`default_nettype wire

// ### verif/pmst_host.sv
`timescale 1ns/1ps
`default_nettype none
module pmst_host
(
  input  wire logic       core_clk_i,
  output logic            cmd_valid_o,
  output logic      [7:0] cmd_code_o
);
  initial
  begin
    cmd_valid_o = 1'h0;
    cmd_code_o  = 8'hFF;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one request; caller enters 1 ns after a rising edge
  task automatic send(input logic [7:0] c);
    cmd_code_o  = c;
    cmd_valid_o = 1'h1;
    @(posedge core_clk_i);
    #1;
    cmd_valid_o = 1'h0;
    // idle code inverted so a stale code is never mistaken for live
    cmd_code_o  = ~c;
    // answer cycle refuses requests, so at least one more edge
    repeat (1 + $urandom_range(2, 0)) @(posedge core_clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ### verif/pmst_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pmst_regs_chk
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        cmd_valid_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic        input_undervolt_fault_i,
  input wire logic        input_undervolt_warning_i,
  input wire logic        input_overvolt_warning_i,
  input wire logic        input_overvolt_fault_i,
  input wire logic        ext_overtemp_warning_i,
  input wire logic        ext_overtemp_fault_i,
  input wire logic        die_overtemp_warning_i,
  input wire logic        die_overtemp_fault_i,
  input wire logic        bus_timeout_format_fault_i,
  input wire logic        packet_check_fault_i,
  input wire logic        bad_command_fault_i,
  input wire logic        rsp_valid_o,
  input wire logic [15:0] rsp_data_o,
  input wire logic [1:0]  rsp_bytes_o,
  input wire logic        rsp_unsupported_o,
  input wire logic        alert_o,
  input wire logic [15:0] status_summary_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_in_uvf_flag:
    assert property (input_undervolt_fault_i |-> ##2 alert_o && status_summary_o[13])
      else $error("input under-voltage fault not flagged");
  a_in_uvw_flag:
    assert property (input_undervolt_warning_i |-> ##2 alert_o && status_summary_o[13])
      else $error("input under-voltage warning not flagged");
  a_in_ov_flag:
    assert property (input_overvolt_warning_i || input_overvolt_fault_i |-> ##2
      status_summary_o[13]) else $error("input over-voltage not flagged");
  a_ext_temp_flag:
    assert property (ext_overtemp_warning_i || ext_overtemp_fault_i |-> ##2
      status_summary_o[2]) else $error("external temperature not flagged");
  a_comm_fault_flag:
    assert property (bus_timeout_format_fault_i || packet_check_fault_i ||
      bad_command_fault_i |-> ##2 status_summary_o[1]) else $error("comm fault not flagged");
  a_die_temp_flag:
    assert property (die_overtemp_warning_i || die_overtemp_fault_i |-> ##2
      status_summary_o[12]) else $error("die temperature not flagged");
  a_summary_mask:
    assert property ((status_summary_o & 16'hCFF9) == 16'h0000)
      else $error("unsupported summary bit set");
  a_alert_level:
    assert property (alert_o == (status_summary_o != 16'h0000))
      else $error("alert disagrees with latched status");
  a_answer_delay:
    assert property (rsp_valid_o |-> $past(cmd_valid_i, 2) ##1 !rsp_valid_o)
      else $error("answer strobe timing wrong");
  a_unsup_answer:
    assert property (rsp_unsupported_o |-> rsp_valid_o && rsp_bytes_o == 2'h0 &&
      rsp_data_o == 16'h0000) else $error("unsupported answer malformed");
  a_mode_byte:
    assert property (rsp_valid_o && $past(cmd_code_i, 2) == 8'h20 |->
      rsp_bytes_o == 2'h1 && rsp_data_o[15:5] == 11'h000) else $error("mode byte malformed");

  c_unsup: cover property (rsp_unsupported_o);
  c_clear: cover property (rsp_valid_o && rsp_bytes_o == 2'h0 && !rsp_unsupported_o);
  c_alert_drop: cover property (alert_o ##1 !alert_o);
endmodule

bind pmst_regs pmst_regs_chk pmst_regs_chk_i (.*);
`default_nettype wire

// ### verif/pmst_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module pmst_regs_test;
  import pmst_pkg::*;
  logic                core_clk_i;
  logic                rst_i;
  logic                cmd_valid;
  logic [7:0]          cmd_code;
  logic [10:0]         fv;
  logic                upd;
  logic [4:0][15:0]    tv;
  logic [EXP_W-1:0]    vexp;
  logic                rsp_valid;
  logic                rsp_unsup;
  logic                alert;
  logic [15:0]         rsp_data;
  logic [15:0]         summary;
  logic [1:0]          rsp_bytes;
  logic [18:0]         q[$];
  int                  n_fail;
  int                  num_checks;
  // fault index order: uvf uvw ovw ovf extw extf diew dief bus pec cmd
  logic [7:0]          gc[11] = '{8'h7C, 8'h7C, 8'h7C, 8'h7C, 8'h7D, 8'h7D,
                                  8'h80, 8'h80, 8'h7E, 8'h7E, 8'h7E};
  int                  bt[11] = '{4, 5, 6, 7, 6, 7, 6, 7, 1, 5, 7};
  int                  sb[11] = '{13, 13, 13, 13, 2, 2, 12, 12, 1, 1, 1};

  initial
  begin
    core_clk_i = 1'h0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  pmst_host pmst_host_i (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code));

  pmst_regs pmst_regs_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
    .input_undervolt_fault_i(fv[0]), .input_undervolt_warning_i(fv[1]),
    .input_overvolt_warning_i(fv[2]), .input_overvolt_fault_i(fv[3]),
    .ext_overtemp_warning_i(fv[4]), .ext_overtemp_fault_i(fv[5]),
    .die_overtemp_warning_i(fv[6]), .die_overtemp_fault_i(fv[7]),
    .bus_timeout_format_fault_i(fv[8]), .packet_check_fault_i(fv[9]),
    .bad_command_fault_i(fv[10]), .telem_update_i(upd),
    .input_voltage_value_i(tv[0]), .output_voltage_value_i(tv[1]),
    .output_voltage_exp_i(vexp), .output_current_value_i(tv[2]),
    .external_temp_value_i(tv[3]), .die_temp_value_i(tv[4]),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_bytes_o(rsp_bytes),
    .rsp_unsupported_o(rsp_unsup), .alert_o(alert), .status_summary_o(summary));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] d, input logic [1:0] b,
                    input logic u);
    q.push_back({d, b, u});
    pmst_host_i.send(c);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // monitor: every answer strobe consumes the oldest note
  always @(negedge core_clk_i)
    if (rst_i === 1'h0 && rsp_valid === 1'h1)
    begin
      if (q.size() == 0)
        chk(19'h00001, 19'h00000);
      else
        chk({rsp_data, rsp_bytes, rsp_unsup}, q.pop_front());
    end

  initial
  begin
    #200000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    rst_i = 1'h1;
    upd   = 1'h0;
    fv    = 11'h000;
    tv    = '0;
    vexp  = 5'h00;
    void'($urandom(68467));
    repeat (16) @(posedge core_clk_i);
    #1;
    rst_i = 1'h0;
    foreach (tv[i]) tv[i] = 16'($urandom);
    vexp = 5'($urandom);
    upd  = 1'h1;
    cyc(1);
    upd  = 1'h0;
    cyc(1);
    // inputs move after capture: answers must come from the snapshot
    rd(8'h88, tv[0], 2'h2, 1'h0);
    tv = ~tv;
    rd(8'h8B, ~tv[1], 2'h2, 1'h0);
    rd(8'h8C, ~tv[2], 2'h2, 1'h0);
    rd(8'h8D, ~tv[3], 2'h2, 1'h0);
    rd(8'h8E, ~tv[4], 2'h2, 1'h0);
    rd(8'h20, {11'h000, vexp}, 2'h1, 1'h0);
    for (int i = 0; i < 11; i++)
    begin
      fv = 11'h001 << i;
      cyc(3);
      chk({2'h0, alert, 16'h0001 << sb[i]}, {2'h0, 1'h1, 16'h0001 << sb[i]});
      chk({2'h0, alert, summary}, {2'h0, 1'h1, 16'h0001 << sb[i]});
      rd(gc[i], 16'h0001 << bt[i], 2'h1, 1'h0);
      rd(8'h03, 16'h0000, 2'h0, 1'h0);
      cyc(1);
      rd(gc[i], 16'h0001 << bt[i], 2'h1, 1'h0);
      fv = 11'h000;
      cyc(1);
      rd(8'h03, 16'h0000, 2'h0, 1'h0);
      cyc(1);
      rd(gc[i], 16'h0000, 2'h1, 1'h0);
      cyc(2);
      chk({2'h0, alert, summary}, 19'h00000);
    end
    fv = 11'h7FF;
    cyc(3);
    chk({3'h0, summary}, 19'h03006);
    rd(8'h7C, 16'h00F0, 2'h1, 1'h0);
    rd(8'h7D, 16'h00C0, 2'h1, 1'h0);
    rd(8'h7E, 16'h00A2, 2'h1, 1'h0);
    rd(8'h80, 16'h00C0, 2'h1, 1'h0);
    fv = 11'h000;
    cyc(1);
    rd(8'h03, 16'h0000, 2'h0, 1'h0);
    cyc(1);
    rd(8'($urandom_range(8'hFF, 8'hA0)), 16'h0000, 2'h0, 1'h1);
    cyc(2);
    rd(8'h7E, 16'h0080, 2'h1, 1'h0);
    cyc(4);
    // mid-run reset must drop the latched command fault and the snapshot
    rst_i = 1'h1;
    cyc(2);
    rst_i = 1'h0;
    chk({2'h0, alert, summary}, 19'h00000);
    rd(8'h7E, 16'h0000, 2'h1, 1'h0);
    rd(8'h88, 16'h0000, 2'h2, 1'h0);
    cyc(4);
    // a note left unanswered means a lost answer
    chk(19'(q.size()), 19'h00000);
    complete_run();
  end
endmodule
`default_nettype wire
